// ===== hdl/core_decode_pkg.sv
// package: field layout, opcode groups, sequencer states and timing of the instruction decoder
package core_decode_pkg;

  // ==========================================================================
  // instruction set size and word layout
  // ==========================================================================
  localparam int STD_INSTR_COUNT = 75;
  localparam int EXT_INSTR_COUNT = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int PROG_W = 20;
  localparam int TOP_LSB = 12;
  localparam int HB_LSB = 8;
  localparam int F_LSB = 0;
  localparam int F_W = 8;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam int B_LSB = 9;
  localparam int B_W = 3;
  localparam int K_W = 8;
  localparam int FSR_LSB = 4;
  localparam int FSR_W = 2;
  localparam int S_BIT = 0;
  localparam int MM_LSB = 0;
  localparam int MM_W = 2;
  localparam int N_W = 11;
  localparam int WIDE_K_HI_W = 4;

  // ==========================================================================
  // opcode groups, keyed on the upper nibble, the upper byte and low-byte tags
  // ==========================================================================
  localparam logic [3:0] TOP_MISC = 4'h0;
  localparam logic [3:0] TOP_BYTE_LO = 4'h1;
  localparam logic [3:0] TOP_SKIP = 4'h6;
  localparam logic [3:0] TOP_BIT_LO = 4'h7;
  localparam logic [3:0] TOP_BTEST_LO = 4'hA;
  localparam logic [3:0] TOP_BIT_HI = 4'hB;
  localparam logic [3:0] TOP_MOVE2 = 4'hC;
  localparam logic [3:0] TOP_BRA = 4'hD;
  localparam logic [3:0] TOP_SECOND = 4'hF;
  localparam logic [7:0] HB_CTRL = 8'h00;
  localparam logic [7:0] HB_BCC_LO = 8'hE0;
  localparam logic [7:0] HB_BCC_HI = 8'hE7;
  localparam logic [7:0] HB_EXT_LO = 8'hE8;
  localparam logic [7:0] HB_EXT_HI = 8'hEB;
  localparam logic [7:0] HB_CALL = 8'hEC;
  localparam logic [7:0] HB_LFSR = 8'hEE;
  localparam logic [7:0] HB_GOTO = 8'hEF;
  localparam logic [4:0] LB_TBL_TAG = 5'h01;
  localparam logic [5:0] LB_RET_TAG = 6'h04;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    CLS_BYTE = 2'h0,
    CLS_BIT = 2'h1,
    CLS_LIT = 2'h2,
    CLS_CTRL = 2'h3
  } op_class_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_SECOND = 2'h1,
    ST_FLUSH = 2'h3
  } seq_state_t;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int OSC_PER_ICYCLE = 4;
  localparam int CLK_HZ = 10_000_000;
  localparam int ICYCLE_NS = OSC_PER_ICYCLE * 1000 / (CLK_HZ / 1_000_000);
  localparam int REF_OSC_HZ = 4_000_000;
  localparam int REF_ICYCLE_NS = OSC_PER_ICYCLE * 1000 / (REF_OSC_HZ / 1_000_000);

endpackage

// ===== hdl/decode_if.sv
// interface: one program word in, its split fields out
interface decode_if;
  logic [15:0] word;
  logic ext_en;
  core_decode_pkg::op_class_t cls;
  logic is_first2;
  logic is_second;
  logic is_cond;
  logic is_jump;
  logic is_ext;
  logic ext_bad;
  logic table_op;
  logic [7:0] opcode;
  logic [7:0] file_addr;
  logic dest_file;
  logic banked;
  logic [2:0] bit_num;
  logic [7:0] literal;
  logic [1:0] fsr_sel;
  logic fast;
  logic [1:0] tmode;
  logic [10:0] n_field;

  modport extract (
    input word, ext_en,
    output cls, is_first2, is_second, is_cond, is_jump, is_ext, ext_bad, table_op,
    output opcode, file_addr, dest_file, banked, bit_num, literal, fsr_sel, fast,
    output tmode, n_field
  );
  modport use_fields (
    output word, ext_en,
    input cls, is_first2, is_second, is_cond, is_jump, is_ext, ext_bad, table_op,
    input opcode, file_addr, dest_file, banked, bit_num, literal, fsr_sel, fast,
    input tmode, n_field
  );
endinterface

// ===== hdl/op_fields.sv
// module: combinational split of one program word into group and operand fields
module op_fields
(
  decode_if.extract d
);
  logic [3:0] top;
  logic [7:0] hb;
  logic [7:0] lb;

  // ==========================================================================
  // grouping
  // ==========================================================================
  always_comb
  begin
    top = d.word[15:core_decode_pkg::TOP_LSB];
    hb = d.word[15:core_decode_pkg::HB_LSB];
    lb = d.word[7:0];
    d.opcode = hb; // see RL3
    d.is_second = (top == core_decode_pkg::TOP_SECOND); // see RL9
    d.is_first2 = (top == core_decode_pkg::TOP_MOVE2) || (hb == core_decode_pkg::HB_CALL)
      || (hb == core_decode_pkg::HB_LFSR) || (hb == core_decode_pkg::HB_GOTO); // see RL2
    d.is_ext = (hb >= core_decode_pkg::HB_EXT_LO) && (hb <= core_decode_pkg::HB_EXT_HI);
    d.ext_bad = d.is_ext && !d.ext_en; // see RL1
    d.table_op = (hb == core_decode_pkg::HB_CTRL)
      && (lb[7:3] == core_decode_pkg::LB_TBL_TAG);
    d.is_jump = (top == core_decode_pkg::TOP_BRA) || (hb == core_decode_pkg::HB_CALL)
      || (hb == core_decode_pkg::HB_GOTO)
      || ((hb == core_decode_pkg::HB_CTRL) && (lb[7:2] == core_decode_pkg::LB_RET_TAG));
    d.is_cond = (top == core_decode_pkg::TOP_SKIP)
      || ((top >= core_decode_pkg::TOP_BTEST_LO) && (top <= core_decode_pkg::TOP_BIT_HI))
      || ((hb >= core_decode_pkg::HB_BCC_LO) && (hb <= core_decode_pkg::HB_BCC_HI));
    // see RL4
    if (top == core_decode_pkg::TOP_MISC)
      d.cls = (hb == core_decode_pkg::HB_CTRL) ? core_decode_pkg::CLS_CTRL
        : core_decode_pkg::CLS_LIT;
    else if ((top >= core_decode_pkg::TOP_BYTE_LO) && (top <= core_decode_pkg::TOP_SKIP))
      d.cls = core_decode_pkg::CLS_BYTE;
    else if (top == core_decode_pkg::TOP_MOVE2)
      d.cls = core_decode_pkg::CLS_BYTE;
    else if ((top >= core_decode_pkg::TOP_BIT_LO) && (top <= core_decode_pkg::TOP_BIT_HI))
      d.cls = core_decode_pkg::CLS_BIT;
    else if (hb == core_decode_pkg::HB_LFSR)
      d.cls = core_decode_pkg::CLS_LIT;
    else
      d.cls = core_decode_pkg::CLS_CTRL;
  end

  // ==========================================================================
  // operand fields, always extracted; the group says which are meaningful
  // ==========================================================================
  always_comb
  begin
    d.file_addr = d.word[core_decode_pkg::F_LSB +: core_decode_pkg::F_W]; // see RL5
    d.dest_file = d.word[core_decode_pkg::D_BIT]; // see RL5
    d.banked = d.word[core_decode_pkg::A_BIT]; // see RL14
    d.bit_num = d.word[core_decode_pkg::B_LSB +: core_decode_pkg::B_W]; // see RL6
    d.literal = d.word[0 +: core_decode_pkg::K_W]; // see RL7
    d.fsr_sel = d.word[core_decode_pkg::FSR_LSB +: core_decode_pkg::FSR_W]; // see RL7
    d.fast = d.word[core_decode_pkg::S_BIT]; // see RL16
    d.tmode = d.word[core_decode_pkg::MM_LSB +: core_decode_pkg::MM_W]; // see RL15
    d.n_field = d.word[0 +: core_decode_pkg::N_W]; // see RL8
  end
endmodule // op_fields

// ===== hdl/core_instruction_decode_timing.sv
// module: instruction decoder and instruction-cycle sequencer of the core
// Operation
// RL1: decodes 75 standard instructions plus 8 extended ones, gated by ext_en.
// RL2: most instructions are one 16-bit word; four span two words.
// RL3: a one-word instruction splits into opcode and operand fields.
// RL4: every instruction is grouped as byte, bit, literal or control.
// RL5: byte ops carry file address, destination and access bits; d=0 targets accumulator.
// RL6: bit ops carry file address, bit number and access bit.
// RL7: literal ops carry a constant, optionally a pointer register select.
// RL8: control ops carry program address, fast select, table mode or nothing.
// RL9: two-word instructions hold 32 bits; second word top nibble is all ones.
// RL10: a second word executed on its own behaves as a no-operation.
// RL11: one-word ops take one cycle; taken tests or jumps add a nop cycle.
// RL12: every two-word instruction takes two instruction cycles.
// RL13: one instruction cycle is four oscillator periods.
// RL14: access bit clear uses the fixed region; set uses the bank selector.
// RL15: table mode picks no change, post-inc, post-dec or pre-inc.
// RL16: fast select clear leaves shadows alone; set saves or restores them.
// RL17: unlisted patterns decode consistently, extended ones as nop when disabled.
module core_instruction_decode_timing
#(
  parameter int Q_PHASES = core_decode_pkg::OSC_PER_ICYCLE
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] instr_word,
  input wire logic ext_en,
  input wire logic cond_true,
  output logic icycle_strobe,
  output logic word_dropped,
  output logic exec_valid,
  output logic exec_nop,
  output logic two_word,
  output logic is_extended,
  output core_decode_pkg::op_class_t op_class,
  output logic [7:0] opcode,
  output logic [11:0] file_addr,
  output logic [11:0] dst_addr,
  output logic dest_file,
  output logic banked,
  output logic [2:0] bit_num,
  output logic [11:0] literal,
  output logic [1:0] fsr_sel,
  output logic [19:0] prog_addr,
  output logic fast_mode,
  output logic table_op,
  output logic [1:0] table_mode
);
  localparam int QW = (Q_PHASES > 2) ? $clog2(Q_PHASES) : 1;
  localparam logic [QW-1:0] Q_LAST = QW'(Q_PHASES - 1);

  if (Q_PHASES < 2)
  begin : g_bad_phases
    $error("Q_PHASES must be at least 2");
  end

  decode_if dif ();

  op_fields u_fields
  (
    .d(dif.extract)
  );

  logic [QW-1:0] q_reg;
  logic boundary;
  core_decode_pkg::seq_state_t state_reg;
  core_decode_pkg::seq_state_t state_next;
  logic [15:0] first_reg;
  logic jump_reg;
  logic cond_reg;
  logic flush_due;
  logic orphan;

  assign dif.word = instr_word;
  assign dif.ext_en = ext_en;

  // ==========================================================================
  // oscillator phase counter
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_reg <= '0;
    else if (q_reg == Q_LAST)
      q_reg <= '0; // see RL13
    else
      q_reg <= q_reg + QW'(1);
  end

  assign boundary = (q_reg == Q_LAST);
  assign icycle_strobe = boundary;
  // a taken test or one-word jump throws away the word fetched behind it
  assign flush_due = (state_reg == core_decode_pkg::ST_EXEC)
    && (jump_reg || (cond_reg && cond_true)); // see RL11
  // second words outside a two-word pair and disabled extended codes never reach the datapath as work
  assign orphan = dif.is_second || dif.ext_bad; // see RL10 see RL17
  assign word_dropped = boundary && flush_due;

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      core_decode_pkg::ST_EXEC,
      core_decode_pkg::ST_FLUSH:
      begin
        if (flush_due)
          state_next = core_decode_pkg::ST_FLUSH;
        else if (dif.is_first2)
          state_next = core_decode_pkg::ST_SECOND; // see RL12
        else
          state_next = core_decode_pkg::ST_EXEC;
      end
      core_decode_pkg::ST_SECOND:
        state_next = core_decode_pkg::ST_EXEC;
      default:
        state_next = core_decode_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= core_decode_pkg::ST_EXEC;
    else if (boundary)
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      first_reg <= 16'h0000;
    else if (boundary && (state_next == core_decode_pkg::ST_SECOND))
      first_reg <= instr_word;
  end

  // what the instruction now issued will demand of the next boundary
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jump_reg <= 1'b0;
      cond_reg <= 1'b0;
    end
    else if (boundary)
    begin
      if (state_reg == core_decode_pkg::ST_SECOND || flush_due || orphan || dif.is_first2)
      begin
        jump_reg <= 1'b0;
        cond_reg <= 1'b0;
      end
      else
      begin
        jump_reg <= dif.is_jump;
        cond_reg <= dif.is_cond;
      end
    end
  end

  // ==========================================================================
  // issued instruction
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exec_valid <= 1'b0;
      exec_nop <= 1'b0;
      two_word <= 1'b0;
    end
    else if (boundary)
    begin
      if (state_reg == core_decode_pkg::ST_SECOND)
      begin
        exec_valid <= 1'b1; // see RL12
        exec_nop <= 1'b0;
        two_word <= 1'b1;
      end
      else if (flush_due || orphan)
      begin
        exec_valid <= 1'b1; // see RL11 see RL10
        exec_nop <= 1'b1;
        two_word <= 1'b0;
      end
      else
      begin
        exec_valid <= !dif.is_first2;
        exec_nop <= 1'b0;
        two_word <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_class <= core_decode_pkg::CLS_CTRL;
      opcode <= 8'h00;
      is_extended <= 1'b0;
      file_addr <= 12'h000;
      dst_addr <= 12'h000;
      dest_file <= 1'b0;
      banked <= 1'b0;
      bit_num <= 3'h0;
      literal <= 12'h000;
      fsr_sel <= 2'h0;
      prog_addr <= 20'h00000;
      fast_mode <= 1'b0;
      table_op <= 1'b0;
      table_mode <= 2'h0;
    end
    else if (boundary && state_reg == core_decode_pkg::ST_SECOND)
    begin
      // the operands of a two-word instruction span both words
      file_addr <= first_reg[11:0]; // see RL9
      dst_addr <= instr_word[11:0];
      literal <= {first_reg[0 +: core_decode_pkg::WIDE_K_HI_W], instr_word[7:0]};
      prog_addr <= {instr_word[11:0], first_reg[7:0]};
    end
    else if (boundary && !flush_due)
    begin
      op_class <= dif.cls; // see RL4
      opcode <= dif.opcode; // see RL3
      is_extended <= dif.is_ext; // see RL1
      file_addr <= {4'h0, dif.file_addr}; // see RL5 see RL6
      dst_addr <= 12'h000;
      dest_file <= dif.dest_file; // see RL5
      banked <= dif.banked; // see RL14
      bit_num <= dif.bit_num; // see RL6
      literal <= {4'h0, dif.literal}; // see RL7
      fsr_sel <= dif.fsr_sel; // see RL7
      prog_addr <= {9'h000, dif.n_field}; // see RL8
      fast_mode <= dif.fast; // see RL16
      table_op <= dif.table_op;
      table_mode <= dif.tmode; // see RL15
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_quiet_phases;
    !boundary [*3];
  endsequence
  sequence seq_next_icycle;
    seq_quiet_phases ##1 boundary;
  endsequence

  chk_cycle_four_osc: assert property (boundary |=> seq_next_icycle) // see RL13
    else $error("instruction cycle is not four clocks");
  chk_orphan_nop: assert property (boundary && dif.is_second // see RL10
    && state_reg != core_decode_pkg::ST_SECOND && !flush_due |=> exec_valid && exec_nop)
    else $error("orphan second word did not run as nop");
  chk_two_word_span: assert property (boundary && dif.is_first2 // see RL12
    && state_reg != core_decode_pkg::ST_SECOND && !flush_due
    |=> !exec_valid ##4 (exec_valid && two_word))
    else $error("two-word instruction did not issue on second cycle");
  chk_jump_flush: assert property (boundary && jump_reg // see RL11
    && state_reg == core_decode_pkg::ST_EXEC
    |=> exec_nop && state_reg == core_decode_pkg::ST_FLUSH)
    else $error("jump not followed by nop cycle");
  chk_skip_taken: assert property (boundary && cond_reg && cond_true // see RL11
    && state_reg == core_decode_pkg::ST_EXEC |=> exec_valid && exec_nop)
    else $error("taken test not followed by nop cycle");
  chk_single_cycle: assert property (boundary && !flush_due && !orphan // see RL11
    && !dif.is_first2 && state_reg != core_decode_pkg::ST_SECOND
    |=> exec_valid && !exec_nop && !two_word)
    else $error("one-word instruction not issued in one cycle");
  chk_dest_select: assert property (boundary && !flush_due // see RL5 see RL14
    && state_reg != core_decode_pkg::ST_SECOND
    |=> dest_file == $past(instr_word[core_decode_pkg::D_BIT])
    && banked == $past(instr_word[core_decode_pkg::A_BIT]))
    else $error("destination or access bit not carried");
  chk_bit_number: assert property (boundary && !flush_due // see RL6
    && state_reg != core_decode_pkg::ST_SECOND
    |=> bit_num == $past(instr_word[core_decode_pkg::B_LSB +: core_decode_pkg::B_W]))
    else $error("bit number not carried");
  chk_ext_gate: assert property (boundary && dif.is_ext && !ext_en // see RL1
    && !flush_due && state_reg != core_decode_pkg::ST_SECOND |=> exec_valid && exec_nop)
    else $error("disabled extended instruction executed");
endmodule // core_instruction_decode_timing

// ===== tb/fetch_model.sv
// partner model: program memory fetch with the datapath condition beside each word
module fetch_model
(
  input wire logic clk,
  input wire logic icycle_strobe,
  output logic [15:0] instr_word,
  output logic cond_true
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] fifo[$];
  logic strobe_seen;

  initial
  begin
    instr_word = 16'h0000;
    cond_true = 1'b0;
    strobe_seen = 1'b0;
  end

  // each entry is one whole program word; second words carry an all-ones top nibble
  task automatic push(input logic [15:0] w, input logic c);
    fifo.push_back({c, w});
  endtask

  always @(negedge clk)
    strobe_seen = icycle_strobe;

  // a word leaves only once taken, so a slow strobe never loses one; idle slots show a nop
  always @(posedge clk)
  begin
    if (strobe_seen === 1'b1 && fifo.size() > 0)
      void'(fifo.pop_front());
    #1;
    {cond_true, instr_word} = (fifo.size() > 0) ? fifo[0] : 17'h00000;
  end
endmodule // fetch_model

// ===== tb/core_instruction_decode_timing_tb_top.sv
// testbench: hand-written scenarios for the instruction decoder and cycle sequencer
module core_instruction_decode_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic clk;
  logic rst_n;
  logic ext_en;
  logic [15:0] instr_word;
  logic cond_true;
  logic icycle_strobe;
  logic word_dropped;
  logic exec_valid;
  logic exec_nop;
  logic two_word;
  logic is_extended;
  core_decode_pkg::op_class_t op_class;
  logic [7:0] opcode;
  logic [11:0] file_addr;
  logic [11:0] dst_addr;
  logic dest_file;
  logic banked;
  logic [2:0] bit_num;
  logic [11:0] literal;
  logic [1:0] fsr_sel;
  logic [19:0] prog_addr;
  logic fast_mode;
  logic table_op;
  logic [1:0] table_mode;
  int errors;
  int check_count;
  int cycles;
  logic dropped_seen;

  core_instruction_decode_timing dut (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
    .ext_en(ext_en), .cond_true(cond_true), .icycle_strobe(icycle_strobe),
    .word_dropped(word_dropped), .exec_valid(exec_valid), .exec_nop(exec_nop),
    .two_word(two_word), .is_extended(is_extended), .op_class(op_class), .opcode(opcode),
    .file_addr(file_addr), .dst_addr(dst_addr), .dest_file(dest_file), .banked(banked),
    .bit_num(bit_num), .literal(literal), .fsr_sel(fsr_sel), .prog_addr(prog_addr),
    .fast_mode(fast_mode), .table_op(table_op), .table_mode(table_mode));

  fetch_model mem (.clk(clk), .icycle_strobe(icycle_strobe), .instr_word(instr_word),
    .cond_true(cond_true));

  always #50 clk = ~clk;

  // ==========================================================================
  // run control and comparisons
  // ==========================================================================
  task automatic results();
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // the whole sequence needs under two hundred clock cycles; a stuck strobe ends here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      results();
    end
  end

  task automatic check_val(input string name, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_cls(input core_decode_pkg::op_class_t exp);
    check_count++;
    if (op_class !== exp)
    begin
      errors++;
      $display("wrong value op_class expected %0h seen %0h", exp, op_class);
    end
  endtask

  // returns just after the edge that took a word, once the decode outputs have landed
  task automatic step();
    @(negedge clk iff icycle_strobe === 1'b1);
    dropped_seen = word_dropped;
    @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_period();
    time t0;
    step();
    t0 = $time;
    step();
    check_val("icycle period", 20'(core_decode_pkg::ICYCLE_NS), 20'($time - t0));
  endtask

  task automatic t_byte();
    logic [15:0] w;
    for (int i = 0; i < 2; i++)
    begin
      w = (i == 0) ? 16'h2B5C : 16'h285C;
      mem.push(w, 1'b0);
      step();
      check_cls(core_decode_pkg::CLS_BYTE);
      check_val("opcode", 20'(w[15:8]), 20'(opcode));
      check_val("file_addr", 20'h0005C, 20'(file_addr));
      check_val("dest_file", 20'(w[9]), 20'(dest_file));
      check_val("banked", 20'(w[8]), 20'(banked));
      check_val("exec_valid", 20'h1, 20'(exec_valid));
    end
  endtask

  task automatic t_bit_lit();
    mem.push(16'h7B21, 1'b0);
    mem.push(16'h0E55, 1'b0);
    step();
    check_cls(core_decode_pkg::CLS_BIT);
    check_val("bit_num", 20'h5, 20'(bit_num));
    check_val("file_addr", 20'h00021, 20'(file_addr));
    check_val("banked", 20'h1, 20'(banked));
    step();
    check_cls(core_decode_pkg::CLS_LIT);
    check_val("literal", 20'h00055, 20'(literal));
  endtask

  task automatic t_table();
    for (int m = 0; m < 4; m++)
    begin
      mem.push(16'h0008 | 16'(m), 1'b0);
      step();
      check_cls(core_decode_pkg::CLS_CTRL);
      check_val("table_op", 20'h1, 20'(table_op));
      check_val("table_mode", 20'(m), 20'(table_mode));
    end
  endtask

  // a jump costs exactly one flushed word, then fetch resumes normally
  task automatic t_jump();
    mem.push(16'hD123, 1'b0);
    mem.push(16'h2000, 1'b0);
    mem.push(16'h2100, 1'b0);
    step();
    check_val("prog_addr", 20'h00123, prog_addr);
    check_val("exec_nop", 20'h0, 20'(exec_nop));
    step();
    check_val("word_dropped", 20'h1, 20'(dropped_seen));
    check_val("exec_nop", 20'h1, 20'(exec_nop));
    step();
    check_val("opcode", 20'h21, 20'(opcode));
    check_val("exec_nop", 20'h0, 20'(exec_nop));
  endtask

  // byte skip, bit test and conditional branch, each untaken and then taken
  task automatic t_skip();
    logic [15:0] w;
    core_decode_pkg::op_class_t cls;
    for (int k = 0; k < 3; k++)
    begin
      w = (k == 0) ? 16'h6000 : ((k == 1) ? 16'hA000 : 16'hE000);
      cls = (k == 0) ? core_decode_pkg::CLS_BYTE : core_decode_pkg::CLS_BIT;
      if (k == 2)
        cls = core_decode_pkg::CLS_CTRL;
      for (int c = 0; c < 2; c++)
      begin
        mem.push(w, 1'b0);
        mem.push(16'h2100, 1'(c));
        step();
        check_cls(cls);
        step();
        check_val("word_dropped", 20'(c), 20'(dropped_seen));
        check_val("exec_nop", 20'(c), 20'(exec_nop));
      end
    end
  endtask

  task automatic t_return();
    for (int s = 0; s < 2; s++)
    begin
      mem.push(16'h0010 | 16'(s), 1'b0);
      mem.push(16'h2000, 1'b0);
      step();
      check_val("fast_mode", 20'(s), 20'(fast_mode));
      check_cls(core_decode_pkg::CLS_CTRL);
      step();
      check_val("word_dropped", 20'h1, 20'(dropped_seen));
    end
  endtask

  task automatic t_two_word();
    mem.push(16'hC123, 1'b0);
    mem.push(16'hF456, 1'b0);
    mem.push(16'hEC01, 1'b0);
    mem.push(16'hF0AB, 1'b0);
    mem.push(16'hEE25, 1'b0);
    mem.push(16'hF034, 1'b0);
    mem.push(16'h2100, 1'b0);
    step();
    check_val("exec_valid", 20'h0, 20'(exec_valid));
    step();
    check_val("two_word", 20'h1, 20'(two_word));
    check_val("file_addr", 20'h00123, 20'(file_addr));
    check_val("dst_addr", 20'h00456, 20'(dst_addr));
    step();
    step();
    check_val("prog_addr", 20'h0AB01, prog_addr);
    check_val("fast_mode", 20'h1, 20'(fast_mode));
    step();
    step();
    check_cls(core_decode_pkg::CLS_LIT);
    check_val("fsr_sel", 20'h2, 20'(fsr_sel));
    check_val("literal", 20'h00534, 20'(literal));
    step();
    check_val("word_dropped", 20'h0, 20'(dropped_seen));
    check_val("exec_nop", 20'h0, 20'(exec_nop));
  endtask

  task automatic t_orphan_ext();
    mem.push(16'hF000, 1'b0);
    step();
    check_val("exec_nop", 20'h1, 20'(exec_nop));
    for (int e = 0; e < 2; e++)
    begin
      ext_en = 1'(e);
      mem.push(16'hE812, 1'b0);
      step();
      check_val("is_extended", 20'h1, 20'(is_extended));
      check_val("exec_nop", 20'(1 - e), 20'(exec_nop));
    end
  endtask

  // a reset in mid-run forgets a pending jump and restarts the phase count
  task automatic t_reset();
    mem.push(16'hD123, 1'b0);
    step();
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    check_val("exec_valid", 20'h0, 20'(exec_valid));
    check_val("opcode", 20'h00, 20'(opcode));
    check_cls(core_decode_pkg::CLS_CTRL);
    check_val("icycle_strobe", 20'h0, 20'(icycle_strobe));
    rst_n = 1'b1;
    mem.push(16'h2100, 1'b1);
    step();
    check_val("word_dropped", 20'h0, 20'(dropped_seen));
    check_val("exec_nop", 20'h0, 20'(exec_nop));
    check_val("opcode", 20'h21, 20'(opcode));
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ext_en = 1'b1;
    errors = 0;
    check_count = 0;
    cycles = 0;
    dropped_seen = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step();
    t_period();
    t_byte();
    t_bit_lit();
    t_table();
    t_jump();
    t_skip();
    t_return();
    t_two_word();
    t_orphan_ext();
    t_reset();
    results();
  end
endmodule // core_instruction_decode_timing_tb_top
